// ### bench/sdp_host_test.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module sdp_host_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic reqValid = 1'b0, reqReady, wrValid = 1'b0, wrReady, rdValid;
  logic memClk, memClk_n, memReset_n;
  logic [1:0] writeByteMask, dataOe, strobeIn, strobeOut, strobeOut_n, strobeOe;
  logic [15:0] rdData, dataIn, dataOut;
  sdp_pkg::sdp_req_t   req = '0;
  sdp_pkg::sdp_wdata_t wrData = '0;
  sdp_pkg::sdp_cmd_t   memCmd;
  int failures = 0, samplesChecked = 0, cycles = 0;
  logic wrPhase = 1'b0, lastClk = 1'b0;
  logic [15:0] got [$];
  sdp_pkg::sdp_req_t rowReq [7];
  logic [20:0] rowCmd [7];
  always #25 mclk = ~mclk;

  sdp_host #(.FIFO_DEPTH(16)) dut (.mclk(mclk), .arst_n(arst_n), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdData(rdData), .memClk(memClk), .memClk_n(memClk_n),
    .memReset_n(memReset_n), .memCmd(memCmd), .writeByteMask(writeByteMask), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .strobeIn(strobeIn), .strobeOut(strobeOut),
    .strobeOut_n(strobeOut_n), .strobeOe(strobeOe));
  sdp_mem_model model (.mclk(mclk), .memCmd(memCmd), .memReset_n(memReset_n),
    .writeByteMask(writeByteMask), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
    .strobeIn(strobeIn));

  function automatic sdp_pkg::sdp_req_t mk(sdp_pkg::sdp_op_t o, logic [2:0] b, logic [13:0] a,
                                           logic ap, logic ch);
    return '{op: o, bank: b, addr: a, autoPre: ap, chop: ch};
  endfunction
  function automatic logic [15:0] wd(int i);
    return 16'(16'h1111 * (i + 1));
  endfunction
  function automatic logic [1:0] wm(int i);
    return (i == 2) ? 2'h1 : (i == 5) ? 2'h2 : 2'h0;
  endfunction
  function automatic logic [15:0] expWord(int i);
    logic [15:0] e;
    e = wd(i);
    if (wm(i)[0])
      e[7:0] = 8'h00;
    if (wm(i)[1])
      e[15:8] = 8'h00;
    return e;
  endfunction

  task automatic issue(input sdp_pkg::sdp_req_t r);
    int n;
    n        = 0;
    // One edge between requests, so reqValid never changes twice at once
    @(posedge mclk);
    #1;
    req      = r;
    reqValid = 1'b1;
    @(negedge mclk);
    while (reqReady !== 1'b1 && n < 200) begin
      n++;
      @(negedge mclk);
    end
    if (n >= 200)
      failures++;
    @(posedge mclk);
    #1 reqValid = 1'b0;
  endtask

  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      wrData  = '{data: wd(i), mask: wm(i)};
      wrValid = 1'b1;
      @(negedge mclk);
      @(posedge mclk);
      #1;
    end
    wrValid = 1'b0;
  endtask

  task automatic collect(input int n, input int first, input logic zero);
    for (int k = 0; k < 100 && got.size() < n; k++)
      @(negedge mclk);
    repeat (20) @(negedge mclk);
    `CHECK(got.size(), n)
    for (int i = 0; i < n && i < got.size(); i++)
      `CHECK(got[i], zero ? 16'h0000 : expWord(first + i))
    got.delete();
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(negedge mclk) begin
    if (rdValid === 1'b1)
      got.push_back(rdData);
    if (strobeOe !== 2'h0)
      `CHECK(strobeOut_n, ~strobeOut)
    if (dataOe !== 2'h0) begin
      `CHECK(strobeOe, dataOe)
      `CHECK(strobeOut, {2{wrPhase}})
      wrPhase = ~wrPhase;
    end else begin
      wrPhase = 1'b0;
    end
    if (memReset_n === 1'b1)
      `CHECK(memClk, ~lastClk)
    lastClk = memClk;
  end

  // Run is a few hundred cycles; this ceiling is ample
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    rowReq[0] = mk(sdp_pkg::OP_ACT, 3'h3, 14'h2a5c, 1'b0, 1'b0);
    rowCmd[0] = {sdp_pkg::CMD_ACT, 3'h3, 14'h2a5c};
    rowReq[1] = mk(sdp_pkg::OP_MRS, 3'h2, 14'h0018, 1'b0, 1'b0);
    rowCmd[1] = {sdp_pkg::CMD_MRS, 3'h2, 14'h0018};
    rowReq[2] = mk(sdp_pkg::OP_PRE, 3'h5, 14'h0000, 1'b0, 1'b0);
    rowCmd[2] = {sdp_pkg::CMD_PRE, 3'h5, 14'h0000};
    rowReq[3] = mk(sdp_pkg::OP_PRE, 3'h1, 14'h0000, 1'b1, 1'b0);
    rowCmd[3] = {sdp_pkg::CMD_PRE, 3'h1, 14'h0400};
    rowReq[4] = mk(sdp_pkg::OP_ACT, 3'h1, 14'h3fff, 1'b0, 1'b0);
    rowCmd[4] = {sdp_pkg::CMD_ACT, 3'h1, 14'h3fff};
    rowReq[5] = mk(sdp_pkg::OP_RD, 3'h1, 14'h3fff, 1'b1, 1'b0);
    rowCmd[5] = {sdp_pkg::CMD_RD, 3'h1, 14'h17ff};
    rowReq[6] = mk(sdp_pkg::OP_RD, 3'h1, 14'h0005, 1'b0, 1'b1);
    rowCmd[6] = {sdp_pkg::CMD_RD, 3'h1, 14'h0005};
    repeat (16) @(posedge mclk);
    #1 arst_n = 1'b1;
    @(posedge mclk);
    #1;
    `CHECK(memReset_n, 1'b1)
    for (int i = 0; i < 7; i++) begin
      issue(rowReq[i]);
      `CHECK(memCmd, sdp_pkg::sdp_cmd_t'(rowCmd[i]))
      @(posedge mclk);
      #1;
      `CHECK(memCmd.cs_n, 1'b1)
    end
    repeat (30) @(posedge mclk);
    #1 got.delete();
    issue(mk(sdp_pkg::OP_ACT, 3'h2, 14'h0007, 1'b0, 1'b0));
    fill(16);
    @(negedge mclk);
    `CHECK(wrReady, 1'b0)
    issue(mk(sdp_pkg::OP_WR, 3'h2, 14'h0000, 1'b0, 1'b0));
    issue(mk(sdp_pkg::OP_WR, 3'h2, 14'h0008, 1'b0, 1'b0));
    issue(mk(sdp_pkg::OP_RD, 3'h2, 14'h0000, 1'b0, 1'b0));
    issue(mk(sdp_pkg::OP_RD, 3'h2, 14'h0008, 1'b0, 1'b0));
    collect(16, 0, 1'b0);
    issue(mk(sdp_pkg::OP_RD, 3'h2, 14'h0004, 1'b0, 1'b1));
    collect(4, 4, 1'b0);
    issue(mk(sdp_pkg::OP_RST, 3'h0, 14'h0000, 1'b0, 1'b0));
    `CHECK(memReset_n, 1'b0)
    issue(mk(sdp_pkg::OP_ACT, 3'h2, 14'h0007, 1'b0, 1'b0));
    `CHECK(memReset_n, 1'b1)
    issue(mk(sdp_pkg::OP_RD, 3'h2, 14'h0000, 1'b0, 1'b1));
    collect(4, 0, 1'b1);
    print_verdict();
  end
endmodule

// ### bench/sdp_mem_model.sv
`timescale 1ns/1ns
module sdp_mem_model (
  // Clock
  input  wire logic                      mclk,
  // Command side
  input  wire sdp_pkg::sdp_cmd_t         memCmd,
  input  wire logic                      memReset_n,
  // Data side
  input  wire logic [1:0]                writeByteMask,
  input  wire logic [15:0]               dataOut,
  input  wire logic [1:0]                dataOe,
  output logic      [15:0]               dataIn,
  output logic      [1:0]                strobeIn
);
  logic [15:0] mem [int];
  logic [13:0] openRow [8];
  logic [13:0] modeReg [8];
  logic [7:0]  rowOpen;
  logic [15:0] rdDrive = 16'h5a5a;
  int          wrKey;
  int          wrLeft;
  int          rdKey;
  int          rdLen;
  initial strobeIn = 2'h0;
  // Bus level worked out from the host's byte enables (dataOe) only
  assign dataIn[7:0]  = dataOe[0] ? dataOut[7:0] : rdDrive[7:0];
  assign dataIn[15:8] = dataOe[1] ? dataOut[15:8] : rdDrive[15:8];

  function automatic int key(input logic [2:0] b, input logic [9:0] c);
    if (!rowOpen[b])
      return -1;
    return int'({b, openRow[b], c});
  endfunction

  // Edge-aligned read beats; closed bank gives garbage
  task automatic read_burst(input int k, input int n);
    repeat (2) @(posedge mclk);
    #1;
    for (int i = 0; i < n; i++) begin
      // Unwritten or erased cells read as zero
      rdDrive  = (k < 0) ? ~rdDrive : mem.exists(k + i) ? mem[k + i] : 16'h0000;
      strobeIn = ~strobeIn;
      @(posedge mclk);
      #1;
    end
    rdDrive = ~rdDrive;
  endtask

  // Contents do not survive a reset
  always @(negedge memReset_n) begin
    mem.delete();
    rowOpen = 8'h00;
    wrLeft  = 0;
  end

  // Sampled mid-cycle, where the command is settled
  always @(negedge mclk) begin
    if (memReset_n && !memCmd.cs_n) begin
      case ({memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n})
        sdp_pkg::CMD_ACT: begin
          openRow[memCmd.bank] = memCmd.addr;
          rowOpen[memCmd.bank] = 1'b1;
        end
        sdp_pkg::CMD_MRS: modeReg[memCmd.bank] = memCmd.addr;
        sdp_pkg::CMD_PRE: begin
          if (memCmd.addr[10])
            rowOpen = 8'h00;
          else
            rowOpen[memCmd.bank] = 1'b0;
        end
        sdp_pkg::CMD_WR: begin
          wrKey  = key(memCmd.bank, memCmd.addr[9:0]);
          wrLeft = memCmd.addr[12] ? 8 : 4;
          if (memCmd.addr[10])
            rowOpen[memCmd.bank] = 1'b0;
        end
        sdp_pkg::CMD_RD: begin
          // Key taken before auto precharge closes the row
          rdKey = key(memCmd.bank, memCmd.addr[9:0]);
          rdLen = memCmd.addr[12] ? 8 : 4;
          fork
            read_burst(rdKey, rdLen);
          join_none
          if (memCmd.addr[10])
            rowOpen[memCmd.bank] = 1'b0;
        end
        default: ;
      endcase
    end
    if (wrLeft > 0 && dataOe != 2'h0) begin
      for (int b = 0; b < 2; b++) begin
        if (wrKey >= 0 && dataOe[b] && !writeByteMask[b]) begin
          if (!mem.exists(wrKey))
            mem[wrKey] = 16'h0000;
          mem[wrKey][8*b +: 8] = dataOut[8*b +: 8];
        end
      end
      if (wrKey >= 0)
        wrKey++;
      wrLeft--;
    end
  end
endmodule

// ### common/sdp_pkg.sv
package sdp_pkg;

  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;
  localparam int BANK_W = 3;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int BURST_FULL = 8;
  localparam int BURST_CHOP = 4;

  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_RD    = 4'h5;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;

  typedef enum logic [2:0] {
    OP_ACT = 3'h0,
    OP_RD  = 3'h1,
    OP_WR  = 3'h2,
    OP_PRE = 3'h3,
    OP_MRS = 3'h4,
    OP_RST = 3'h5
  } sdp_op_t;

  typedef struct packed {
    sdp_op_t             op;
    logic [BANK_W-1:0]   bank;
    logic [ROW_W-1:0]    addr;
    logic                autoPre;
    logic                chop;
  } sdp_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]   data;
    logic [1:0]          mask;
  } sdp_wdata_t;

  typedef struct packed {
    logic                cs_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [BANK_W-1:0]   bank;
    logic [ROW_W-1:0]    addr;
  } sdp_cmd_t;

endpackage

// ### logic/sdp_fifo.sv
`timescale 1ns/1ns
module sdp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;

  assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData  = mem[rdPtr_reg[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (inValid && inReady) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= '0;
    end else if (inValid && inReady) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr_reg <= '0;
    end else if (outValid && outReady) begin
      rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule

// ### logic/sdp_host.sv
`timescale 1ns/1ns
module sdp_host #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         arst_n,
  // Request port
  input  wire logic                         reqValid,
  output logic                              reqReady,
  input  wire sdp_pkg::sdp_req_t            req,
  // Write data stream
  input  wire logic                         wrValid,
  output logic                              wrReady,
  input  wire sdp_pkg::sdp_wdata_t          wrData,
  // Read data stream
  output logic                              rdValid,
  output logic [sdp_pkg::DATA_W-1:0]        rdData,
  // Memory pins
  output logic                              memClk,
  output logic                              memClk_n,
  output logic                              memReset_n,
  output sdp_pkg::sdp_cmd_t                 memCmd,
  output logic [1:0]                        writeByteMask,
  input  wire logic [sdp_pkg::DATA_W-1:0]   dataIn,
  output logic [sdp_pkg::DATA_W-1:0]        dataOut,
  output logic [1:0]                        dataOe,
  input  wire logic [1:0]                   strobeIn,
  output logic [1:0]                        strobeOut,
  output logic [1:0]                        strobeOut_n,
  output logic [1:0]                        strobeOe
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } sdp_state_t;

  sdp_state_t                 state_reg;
  logic [3:0]                 beat_reg;
  logic [3:0]                 beats_reg;
  logic                       fifoValid;
  logic                       fifoReady;
  sdp_pkg::sdp_wdata_t        fifoData;
  logic [sdp_pkg::DATA_W-1:0] dinS1_reg;
  logic [sdp_pkg::DATA_W-1:0] dinS2_reg;
  logic [1:0]                 stbS1_reg;
  logic [1:0]                 stbS2_reg;
  logic [1:0]                 stbOld_reg;

  // ------------------------------------------------------------
  // Write data buffer
  // ------------------------------------------------------------
  sdp_fifo #(
    .WIDTH ($bits(sdp_pkg::sdp_wdata_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .inData   (wrData),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  function automatic logic [3:0] burstLen(input logic chop);
    burstLen = chop ? 4'(sdp_pkg::BURST_CHOP) : 4'(sdp_pkg::BURST_FULL);
  endfunction

  // A write starts with one word buffered; beats stall if the buffer runs dry
  logic wrBurstReady;
  assign wrBurstReady = fifoValid;
  assign reqReady  = (state_reg == ST_IDLE) && !(req.op == sdp_pkg::OP_WR && !wrBurstReady);
  assign fifoReady = (state_reg == ST_WRITE);

  // ------------------------------------------------------------
  // Memory clock, sampled by the device on the rising true edge
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      memClk <= 1'b0;
    end else begin
      memClk <= ~memClk;
    end
  end
  assign memClk_n = ~memClk;

  // ------------------------------------------------------------
  // Command and address
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      memCmd     <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      memReset_n <= 1'b0;
    end else begin
      memReset_n <= 1'b1;
      {memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n} <= sdp_pkg::CMD_DESEL;
      if (reqValid && reqReady) begin
        memCmd.bank <= req.bank;
        memCmd.addr <= '0;
        unique case (req.op)
          sdp_pkg::OP_ACT: begin
            {memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n} <= sdp_pkg::CMD_ACT;
            memCmd.addr <= req.addr;
          end
          sdp_pkg::OP_RD, sdp_pkg::OP_WR: begin
            {memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n} <=
              (req.op == sdp_pkg::OP_RD) ? sdp_pkg::CMD_RD : sdp_pkg::CMD_WR;
            memCmd.addr[sdp_pkg::COL_W-1:0] <= req.addr[sdp_pkg::COL_W-1:0];
            memCmd.addr[sdp_pkg::AP_BIT]    <= req.autoPre;
            memCmd.addr[sdp_pkg::BC_BIT]    <= ~req.chop;
          end
          sdp_pkg::OP_PRE: begin
            {memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n} <= sdp_pkg::CMD_PRE;
            memCmd.addr[sdp_pkg::AP_BIT] <= req.autoPre;
          end
          sdp_pkg::OP_MRS: begin
            {memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n} <= sdp_pkg::CMD_MRS;
            memCmd.addr <= req.addr;
          end
          sdp_pkg::OP_RST: begin
            memReset_n <= 1'b0;
          end
          default: begin
            {memCmd.cs_n, memCmd.ras_n, memCmd.cas_n, memCmd.we_n} <= sdp_pkg::CMD_NOP;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Burst sequencing
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      beat_reg  <= '0;
      beats_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          beat_reg <= '0;
          if (reqValid && reqReady && req.op == sdp_pkg::OP_WR) begin
            state_reg <= ST_WRITE;
            beats_reg <= burstLen(req.chop);
          end else if (reqValid && reqReady && req.op == sdp_pkg::OP_RD) begin
            state_reg <= ST_READ;
            beats_reg <= burstLen(req.chop);
          end
        end
        ST_WRITE: begin
          if (fifoValid) begin
            beat_reg <= beat_reg + 4'h1;
            if (beat_reg == beats_reg - 4'h1) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          if (rdValid) begin
            beat_reg <= beat_reg + 4'h1;
            if (beat_reg == beats_reg - 4'h1) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Write data, mask and strobe drive
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut       <= '0;
      dataOe        <= '0;
      writeByteMask <= '0;
      strobeOut     <= '0;
      strobeOe      <= '0;
    end else begin
      dataOe   <= '0;
      strobeOe <= '0;
      if (state_reg == ST_WRITE && fifoValid) begin
        dataOut       <= fifoData.data;
        writeByteMask <= fifoData.mask;
        dataOe        <= 2'h3;
        strobeOe      <= 2'h3;
        strobeOut     <= {2{beat_reg[0]}};
      end
    end
  end
  assign strobeOut_n = ~strobeOut;

  // ------------------------------------------------------------
  // Read capture on device strobe edges
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dinS1_reg  <= '0;
      dinS2_reg  <= '0;
      stbS1_reg  <= '0;
      stbS2_reg  <= '0;
      stbOld_reg <= '0;
    end else begin
      dinS1_reg  <= dataIn;
      dinS2_reg  <= dinS1_reg;
      stbS1_reg  <= strobeIn;
      stbS2_reg  <= stbS1_reg;
      stbOld_reg <= stbS2_reg;
    end
  end

  // Lower strobe paces the beat; both lanes are taken together
  assign rdValid = (state_reg == ST_READ) && (stbS2_reg[0] != stbOld_reg[0]);
  assign rdData  = dinS2_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_act_row: assert property (@(posedge mclk) disable iff (!arst_n)
    reqValid && reqReady && req.op == sdp_pkg::OP_ACT |=> memCmd.addr == $past(req.addr))
    else $error("Row address not presented");
  chk_col_addr: assert property (@(posedge mclk) disable iff (!arst_n)
    reqValid && reqReady && req.op == sdp_pkg::OP_RD |=>
      memCmd.addr[sdp_pkg::COL_W-1:0] == $past(req.addr[sdp_pkg::COL_W-1:0]))
    else $error("Column address wrong");
  chk_mrs_code: assert property (@(posedge mclk) disable iff (!arst_n)
    reqValid && reqReady && req.op == sdp_pkg::OP_MRS |=> memCmd.addr == $past(req.addr))
    else $error("Opcode wrong");
  chk_auto_pre: assert property (@(posedge mclk) disable iff (!arst_n)
    reqValid && reqReady && (req.op == sdp_pkg::OP_WR || req.op == sdp_pkg::OP_PRE) |=>
      memCmd.addr[sdp_pkg::AP_BIT] == $past(req.autoPre))
    else $error("Precharge bit wrong");
  chk_chop_bit: assert property (@(posedge mclk) disable iff (!arst_n)
    reqValid && reqReady && req.op == sdp_pkg::OP_RD |=>
      memCmd.addr[sdp_pkg::BC_BIT] == !$past(req.chop))
    else $error("Chop bit wrong");
  chk_reset_high: assert property (@(posedge mclk) disable iff (!arst_n)
    !(reqValid && reqReady && req.op == sdp_pkg::OP_RST) |=> memReset_n)
    else $error("Memory reset low unasked");
  chk_strobe_pair: assert property (@(posedge mclk) disable iff (!arst_n)
    strobeOut_n == ~strobeOut) else $error("Strobe not differential");
  chk_bank_sel: assert property (@(posedge mclk) disable iff (!arst_n)
    reqValid && reqReady && req.op != sdp_pkg::OP_RST |=> memCmd.bank == $past(req.bank))
    else $error("Bank select wrong");
  chk_idle_desel: assert property (@(posedge mclk) disable iff (!arst_n)
    !(reqValid && reqReady) |=> memCmd.cs_n) else $error("Chip select without request");
  chk_wr_drive: assert property (@(posedge mclk) disable iff (!arst_n)
    dataOe != 2'h0 |-> strobeOe == 2'h3) else $error("Write data without strobe");
  chk_wr_toggle: assert property (@(posedge mclk) disable iff (!arst_n)
    dataOe != 2'h0 && $past(dataOe) != 2'h0 |-> strobeOut != $past(strobeOut))
    else $error("Write strobe not toggling");

  cov_write: cover property (@(posedge mclk) disable iff (!arst_n)
    state_reg == ST_WRITE ##1 state_reg == ST_IDLE);
  cov_read: cover property (@(posedge mclk) disable iff (!arst_n)
    state_reg == ST_READ ##1 state_reg == ST_IDLE);
  cov_full: cover property (@(posedge mclk) disable iff (!arst_n) !wrReady);
endmodule
